// File: src/true_random_word_source.v
// true random word source: register slave around a paced noise sampler
// What this block does
// - value register reads a fresh 16-bit word low, upper bits zero.
// - only 32-bit accesses allowed; narrower ones get an error response.
// - new words come no faster than one per 1.25 microseconds.
// - config bit 2 set stops oscillators and gates generator clock.
// - status bit 0 reads 1 while a valid word is held.
// - reading value while not ready stalls the bus until a word arrives.
// - ready flag stays 0 while generator is off.
// - config at 0x00, status 0x04, value 0x08; all reset to zero.
`timescale 1ns/1ns
`include "rng_regs.vh"
module true_random_word_source #(
   parameter WORD_W = `WORD_W,
   parameter PERIOD = `WORD_PERIOD_CYC
) (
   input wire clock,
   input wire rst,
   input wire sel,
   input wire write,
   input wire [`ADDR_W-1:0] addr,
   input wire [2:0] size,
   input wire [31:0] wdata,
   output reg [31:0] rdata,
   output wire ready,
   output wire error,
   input wire noise_in,
   output wire osc_power_down,
   output wire gen_clock_enable
);
   // ****************************************
   // states and storage
   // ****************************************

   localparam ST_IDLE = 2'b01;
   localparam ST_WAIT = 2'b10;

   reg [1:0] state_ff;
   reg [1:0] nxt_state;

   reg generator_off_ff;
   reg nxt_generator_off;

   reg word_ready_ff;
   reg nxt_word_ready;

   reg [WORD_W-1:0] random_word_ff;
   reg [WORD_W-1:0] nxt_random_word;

   reg [31:0] nxt_rdata;

   wire cap_valid;
   wire [WORD_W-1:0] cap_word;

   wire full_size;
   wire bus_read;
   wire bus_write;
   wire read_config;
   wire read_flags;
   wire read_value;
   wire write_config;
   wire deliver;

   // ****************************************
   // decode helpers
   // ****************************************

   // one compare for every offset keeps all decodes the same width
   function hit;
      input [`ADDR_W-1:0] a;
      input [`ADDR_W-1:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   // size code 2 is the only full-word transfer
   function full_access;
      input [2:0] s;
      begin
         full_access = (s == 3'h2);
      end
   endfunction

   // ****************************************
   // address and access decode
   // ****************************************

   assign full_size = full_access(size);

   // a narrow access never reaches a register, so it cannot half-write one
   assign bus_read = sel && !write && full_size;
   assign bus_write = sel && write && full_size;

   assign read_config = bus_read && hit(addr, `GEN_CONFIG_OFS);
   assign read_flags = bus_read && hit(addr, `GEN_FLAGS_OFS);
   assign read_value = bus_read && hit(addr, `RANDOM_WORD_OFS);

   // flags and word have no write decode, so writes there change nothing
   assign write_config = bus_write && hit(addr, `GEN_CONFIG_OFS);

   // ****************************************
   // generator clock gating and sampler
   // ****************************************

   assign osc_power_down = generator_off_ff;
   assign gen_clock_enable = !generator_off_ff;

   noise_sampler #(.WORD_W(WORD_W), .PERIOD(PERIOD)) u_sampler (
      .clock(clock),
      .rst(rst),
      .run(gen_clock_enable),
      .noise_in(noise_in),
      .word_valid_ff(cap_valid),
      .word_ff(cap_word)
   );

   // ****************************************
   // bus handshake: value read waits for a word
   // ****************************************

   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (read_value && !word_ready_ff) begin
               nxt_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (word_ready_ff || !sel) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // the read completes only once the ready flag is up
   // limitation: a value read while the generator is off waits until it is on
   assign ready = !(read_value && !word_ready_ff);
   assign error = sel && !full_size;
   assign deliver = read_value && word_ready_ff;

   // ****************************************
   // next values
   // ****************************************

   always @* begin
      nxt_generator_off = generator_off_ff;
      if (write_config) begin
         // only the off bit is stored; reserved bits are not kept
         nxt_generator_off = wdata[`GEN_OFF_BIT];
      end
   end

   always @* begin
      nxt_word_ready = word_ready_ff;
      nxt_random_word = random_word_ff;
      if (generator_off_ff) begin
         nxt_word_ready = 1'b0;
      end else if (cap_valid) begin
         // capture wins over the read clear, so a fresh word is never lost
         nxt_word_ready = 1'b1;
         nxt_random_word = cap_word;
      end else if (deliver) begin
         nxt_word_ready = 1'b0;
      end
   end

   always @* begin
      nxt_rdata = 32'h00000000;
      if (read_config) begin
         nxt_rdata[`GEN_OFF_BIT] = generator_off_ff;
      end else if (read_flags) begin
         nxt_rdata[`READY_BIT] = word_ready_ff;
      end else if (deliver) begin
         // upper half stays zero from the default above
         nxt_rdata[WORD_W-1:0] = random_word_ff;
      end
   end

   // ****************************************
   // handshake state register
   // ****************************************

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ****************************************
   // configuration register
   // ****************************************

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         generator_off_ff <= 1'b0;
      end else begin
         generator_off_ff <= nxt_generator_off;
      end
   end

   // ****************************************
   // ready flag and held word
   // ****************************************

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         word_ready_ff <= 1'b0;
         random_word_ff <= `RANDOM_WORD_RST;
      end else begin
         word_ready_ff <= nxt_word_ready;
         random_word_ff <= nxt_random_word;
      end
   end

   // ****************************************
   // read data register
   // ****************************************

   // read data stands one cycle after the accepting edge, then drops to zero
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata <= 32'h00000000;
      end else begin
         rdata <= nxt_rdata;
      end
   end

endmodule

// File: src/rng_regs.vh
// register offsets, field positions, reset values and timing for the random word source
`ifndef RNG_REGS_VH
`define RNG_REGS_VH
// ****************************************
// register map
// ****************************************
`define GEN_CONFIG_OFS 12'h000
`define GEN_FLAGS_OFS 12'h004
`define RANDOM_WORD_OFS 12'h008
`define ADDR_W 12
// ****************************************
// fields and reset values
// ****************************************
`define GEN_OFF_BIT 2
`define READY_BIT 0
`define WORD_W 16
`define GEN_CONFIG_RST 32'h00000000
`define RANDOM_WORD_RST 16'h0000
// ****************************************
// timing
// ****************************************
`define WORD_PERIOD_NS 1250
`define CLOCK_MHZ 50
`define WORD_PERIOD_CYC ((`WORD_PERIOD_NS * `CLOCK_MHZ + 999) / 1000)
`endif

// File: src/noise_sampler.v
// noise sampler: collects synchronised noise bits into words at a fixed pace
`timescale 1ns/1ns
`include "rng_regs.vh"
module noise_sampler #(
   parameter WORD_W = `WORD_W,
   parameter PERIOD = `WORD_PERIOD_CYC
) (
   input wire clock,
   input wire rst,
   input wire run,
   input wire noise_in,
   output reg word_valid_ff,
   output reg [WORD_W-1:0] word_ff
);
   reg sync1_ff;
   reg sync2_ff;
   reg [15:0] count_ff;
   reg [WORD_W-1:0] shift_ff;
   // ****************************************
   // noise pin synchroniser and word pacing
   // ****************************************
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         count_ff <= 16'h0000;
         shift_ff <= {WORD_W{1'b0}};
         word_valid_ff <= 1'b0;
         word_ff <= {WORD_W{1'b0}};
      end else begin
         sync1_ff <= noise_in;
         sync2_ff <= sync1_ff;
         word_valid_ff <= 1'b0;
         if (!run) begin
            // a stopped source restarts a full period later, never early
            count_ff <= 16'h0000;
         end else begin
            shift_ff <= {shift_ff[WORD_W-2:0], sync2_ff ^ shift_ff[WORD_W-1]};
            if (count_ff == PERIOD[15:0] - 16'h0001) begin
               count_ff <= 16'h0000;
               word_valid_ff <= 1'b1;
               word_ff <= {shift_ff[WORD_W-2:0], sync2_ff ^ shift_ff[WORD_W-1]};
            end else begin
               count_ff <= count_ff + 16'h0001;
            end
         end
      end
   end
endmodule

// File: dv/rng_props.sv
// checker: bus and generator-control properties of the random word source
`timescale 1ns/1ns
module rng_props(
   input wire clock, input wire rst, input wire sel, input wire write,
   input wire [11:0] addr, input wire [2:0] size, input wire [31:0] rdata,
   input wire ready, input wire error, input wire osc_power_down, input wire gen_clock_enable);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire vreq = sel && !write && addr == 12'h008 && size == 3'h2;
   wire facc = sel && !write && addr == 12'h004 && size == 3'h2 && ready;
   sequence vacc; vreq && ready; endsequence
   err_size_a: assert property (sel && size != 3'h2 |-> error)
      else $error("narrow access not refused");
   ok_size_a: assert property (sel && size == 3'h2 |-> !error)
      else $error("full access refused");
   hi_zero_a: assert property (vacc |=> rdata[31:16] == 16'h0000)
      else $error("upper word bits set");
   pd_pair_a: assert property (osc_power_down != gen_clock_enable)
      else $error("power down and clock enable disagree");
   off_flag_a: assert property (osc_power_down && facc |=> rdata[0] == 1'b0)
      else $error("ready flag set while off");
   reread_a: assert property (vacc ##1 vreq |-> !ready)
      else $error("word delivered twice");
   pace_a: assert property (vreq && !ready ##1 vacc ##1 vreq [*2] |-> !ready)
      else $error("words too close");
   stall_end_a: assert property (vreq && !ready && !osc_power_down |-> ##[1:70] ready)
      else $error("stalled read never completes");
endmodule
bind true_random_word_source rng_props u_props(.clock, .rst, .sel, .write, .addr, .size,
   .rdata, .ready, .error, .osc_power_down, .gen_clock_enable);

// File: dv/noise_source.sv
// noise source model: free-running bit pattern on the noise input
`timescale 1ns/1ns
module noise_source(output logic noise_out);
   logic [6:0] lfsr_ff = 7'h01;
   // odd step keeps the noise unrelated in phase to the bus clock
   always #7 lfsr_ff = {lfsr_ff[5:0], lfsr_ff[6] ^ lfsr_ff[5]};
   assign noise_out = lfsr_ff[0];
endmodule

// File: dv/test_true_random_word_source.sv
// testbench for the random word source
`timescale 1ns/1ns
module test_true_random_word_source;
   logic clock = 0, rst = 1, sel = 0, write = 0, er;
   logic [11:0] addr = 12'h000;
   logic [2:0] size = 3'h2;
   logic [31:0] wdata = 32'h0, rdata, rd;
   wire ready, error, noise_in, pd, ce;
   int num_errors = 0, total_checks = 0, wt;
   localparam int TB_PERIOD = 4;
   always #10 clock = ~clock;
   true_random_word_source #(.PERIOD(TB_PERIOD)) dut(.clock, .rst, .sel, .write, .addr, .size,
      .wdata, .rdata, .ready, .error, .noise_in, .osc_power_down(pd), .gen_clock_enable(ce));
   noise_source partner(.noise_out(noise_in));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task final_report;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // request held until the edge that sees ready, then one idle cycle
   task bus(input logic w, input logic [11:0] a, input logic [2:0] s, input logic [31:0] d);
      sel = 1; write = w; addr = a; size = s; wdata = d; wt = 0;
      #1;
      while (ready !== 1'b1) begin
         @(posedge clock); #1; wt++;
         if (wt > 99) begin num_errors++; final_report; end
      end
      er = error; @(posedge clock); #1; rd = rdata; sel = 0; @(posedge clock); #1;
   endtask
   task wait_ready(output int n);
      n = 0;
      while (ready !== 1'b1) begin
         @(posedge clock);
         #1;
         n++;
         if (n > 99) begin
            num_errors++;
            final_report;
         end
      end
   endtask
   // three value reads held back to back: the second word is taken the edge after capture
   task t_back;
      int n;
      sel = 1;
      write = 0;
      addr = 12'h008;
      size = 3'h2;
      #1;
      wait_ready(n);
      @(posedge clock);
      #1;
      wait_ready(n);
      @(posedge clock);
      #1;
      chk(ready, 1'b0);
      chk(rdata[31:16], 16'h0000);
      wait_ready(n);
      chk(n, TB_PERIOD - 1);
      @(posedge clock);
      #1;
      sel = 0;
      @(posedge clock);
      #1;
   endtask
   task t_reset;
      bus(0, 12'h004, 3'h2, 32'h0); chk(rd, 32'h0);
      bus(0, 12'h000, 3'h2, 32'h0); chk(rd, 32'h0);
      chk(er, 1'b0);
      chk({pd, ce}, 2'b01);
   endtask
   task t_size;
      for (int s = 0; s < 8; s++) if (s != 2) begin
         bus(1, 12'h000, s[2:0], 32'h4); chk(er, 1'b1);
      end
      bus(0, 12'h000, 3'h2, 32'h0); chk(rd, 32'h0);
   endtask
   task t_word;
      bus(0, 12'h008, 3'h2, 32'h0); chk(rd[31:16], 16'h0000);
      bus(0, 12'h008, 3'h2, 32'h0); chk(wt < TB_PERIOD, 1'b1);
      chk(rd[31:16], 16'h0000);
   endtask
   task t_off;
      bus(1, 12'h000, 3'h2, 32'h4); chk({pd, ce}, 2'b10);
      repeat (10) @(posedge clock);
      #1 bus(0, 12'h004, 3'h2, 32'h0); chk(rd, 32'h0);
      bus(1, 12'h000, 3'h2, 32'h0); chk({pd, ce}, 2'b01);
   endtask
   task t_ro;
      bus(1, 12'h004, 3'h2, 32'h1); bus(1, 12'h008, 3'h2, 32'hFFFF);
      bus(0, 12'h000, 3'h2, 32'h0); chk(rd, 32'h0);
      bus(0, 12'h004, 3'h2, 32'h0); chk(rd, 32'h1);
   endtask
   initial begin
      repeat (6) @(posedge clock);
      #1 rst = 0;
      t_reset; t_size; t_word; t_off; t_ro; t_back;
      final_report;
   end
endmodule
